// file: hdl/adsc_defs.svh
// Constants of the actuator driver serial control port.
// Assumes inclusion by bare name from hdl/.
`ifndef ADSC_DEFS_SVH
`define ADSC_DEFS_SVH
`define ADSC_FRAME_BITS 16
`define ADSC_CNT_W 5
`define ADSC_SEL_LSB 9
`define ADSC_SEL_MSB 11
`define ADSC_NUM_PAIRS 3
`define ADSC_NUM_HS 5
`define ADSC_CTRL_RESET 16'h0000
`define ADSC_FIFO_DEPTH 4
`define ADSC_TEST_SEL_LSB 12
`endif

// file: hdl/adsc_pkg.sv
// Types of the actuator driver serial control port.
// Assumes nothing beyond a SystemVerilog compiler.
package adsc_pkg;
    // Operating mode of one half-bridge pair
    typedef enum logic [1:0] {
        ADSC_HIZ = 2'b00,
        ADSC_FWD = 2'b01,
        ADSC_REV = 2'b10,
        ADSC_BRK = 2'b11
    } adsc_mode_t;
    // Frame state
    typedef enum logic [0:0] {
        ADSC_IDLE = 1'b0,
        ADSC_SHIFT = 1'b1
    } adsc_state_t;
endpackage

// file: hdl/adsc_fifo.sv
// Small FIFO carrying completed control words to the output logic.
// Assumes one clock, active-low asynchronous reset.
`timescale 1ns/1ps
module adsc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic clr_i,
    // Write side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Read side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;
    assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o = mem_q[rd_q];
    // Storage, no reset needed
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end
    // Pointers and fill level
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else if (clr_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// file: hdl/adsc_top.sv
// Serial control port of an actuator power driver: shift, latch, drive.
// Assumes the host is master; link pins are asynchronous to clk_i.
//
// Contract
// [RULE1] Host sends 16 bits, LSB first
// [RULE2] Transfer only while chip select low
// [RULE3] Serial out tristated while deselected
// [RULE4] Shift only on serial clock edges
// [RULE5] Enable low: standby, outputs off
// [RULE6] Standby clears every register; code keeps synchronisers and FIFO storage
// [RULE7] Bits 9..11 select monitored high-side
// [RULE8] Overdriven monitor pin gates outputs as PWM
// [RULE9] High-voltage select enters test mode
// [RULE10] Pairs take forward, reverse, brake, hiz
// [RULE11] Diagnosis readable over serial link
// [RULE12] Deselect edge latches complete frame
`timescale 1ns/1ps
`include "adsc_defs.svh"
module adsc_top #(
    parameter int FRAME_BITS = `ADSC_FRAME_BITS,
    parameter int DEPTH = `ADSC_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Serial link
    input wire logic chip_select_n_i,
    input wire logic serial_clk_i,
    input wire logic serial_in_i,
    output logic serial_out_o,
    output logic serial_out_oe_o,
    // Enable and test entry
    input wire logic enable_i,
    input wire logic test_hv_i,
    // Monitor / PWM pin
    input wire logic monitor_pwm_pin_i,
    output logic monitor_pwm_pin_o,
    output logic monitor_pwm_pin_oe_o,
    // Diagnosis and power stage
    input wire logic [15:0] diag_i,
    output logic [5:0] bridge_mode_o,
    output logic [1:0] hs_on_o,
    output logic [2:0] mon_sel_o,
    output logic standby_o,
    output logic test_mode_o
);
    localparam int CW = `ADSC_CNT_W;
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [2:0] cs_s_q, sck_s_q, sdi_s_q, en_s_q, hv_s_q, pwm_s_q;
    logic cs_q, sck_q, en_q, hv_q, pwm_q;
    // Three stages; a level counts once stages two and three agree
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cs_s_q <= 3'h7;
            sck_s_q <= 3'h0;
            sdi_s_q <= 3'h0;
            en_s_q <= 3'h0;
            hv_s_q <= 3'h0;
            pwm_s_q <= 3'h0;
        end else begin
            cs_s_q <= {cs_s_q[1:0], chip_select_n_i};
            sck_s_q <= {sck_s_q[1:0], serial_clk_i};
            sdi_s_q <= {sdi_s_q[1:0], serial_in_i};
            en_s_q <= {en_s_q[1:0], enable_i};
            hv_s_q <= {hv_s_q[1:0], test_hv_i};
            pwm_s_q <= {pwm_s_q[1:0], monitor_pwm_pin_i};
        end
    end
    // Filtered levels, held until stages agree on a new value
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cs_q <= 1'b1;
            sck_q <= 1'b0;
            en_q <= 1'b0;
            hv_q <= 1'b0;
            pwm_q <= 1'b0;
        end else begin
            if (cs_s_q[1] == cs_s_q[2]) cs_q <= cs_s_q[2];
            if (sck_s_q[1] == sck_s_q[2]) sck_q <= sck_s_q[2];
            if (en_s_q[1] == en_s_q[2]) en_q <= en_s_q[2];
            if (hv_s_q[1] == hv_s_q[2]) hv_q <= hv_s_q[2];
            if (pwm_s_q[1] == pwm_s_q[2]) pwm_q <= pwm_s_q[2];
        end
    end
    // ------------------------------------------------------------
    // Edge decode
    // ------------------------------------------------------------
    wire sck_agree = (sck_s_q[1] == sck_s_q[2]);
    wire sck_rise = sck_agree && sck_s_q[2] && !sck_q;
    wire sck_fall = sck_agree && !sck_s_q[2] && sck_q;
    wire cs_agree = (cs_s_q[1] == cs_s_q[2]);
    wire cs_fall = cs_agree && !cs_s_q[2] && cs_q;
    wire cs_rise = cs_agree && cs_s_q[2] && !cs_q;
    wire standby = !en_q;
    wire selected = !cs_q;
    // ------------------------------------------------------------
    // Frame shifter
    // ------------------------------------------------------------
    adsc_pkg::adsc_state_t st_q;
    logic [FRAME_BITS-1:0] rx_q;
    logic [FRAME_BITS-1:0] tx_q;
    logic [CW-1:0] cnt_q;
    // LSB arrives first, so each bit enters at the top and moves down
    wire [FRAME_BITS-1:0] rx_d = {sdi_s_q[2], rx_q[FRAME_BITS-1:1]}; // RULE1
    wire frame_full = (cnt_q == CW'(FRAME_BITS));
    wire take_bit = (st_q == adsc_pkg::ADSC_SHIFT) && selected && sck_rise;
    // Frames shift only on host clock edges while selected
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= adsc_pkg::ADSC_IDLE;
            rx_q <= '0;
            tx_q <= '0;
            cnt_q <= '0;
        end else if (standby) begin
            st_q <= adsc_pkg::ADSC_IDLE; // RULE6
            rx_q <= '0;
            tx_q <= '0;
            cnt_q <= '0;
        end else begin
            case (st_q)
                adsc_pkg::ADSC_IDLE: begin
                    if (cs_fall) begin // RULE2
                        st_q <= adsc_pkg::ADSC_SHIFT;
                        cnt_q <= '0;
                        tx_q <= diag_i; // RULE11
                    end
                end
                adsc_pkg::ADSC_SHIFT: begin
                    if (cs_rise) begin
                        st_q <= adsc_pkg::ADSC_IDLE;
                        cnt_q <= '0; // Idle count stays still until select
                    end else if (take_bit) begin // RULE4
                        rx_q <= rx_d;
                        if (!frame_full) cnt_q <= cnt_q + 1'b1;
                    end else if (sck_fall && selected) begin
                        tx_q <= {1'b0, tx_q[FRAME_BITS-1:1]};
                    end
                end
                default: st_q <= adsc_pkg::ADSC_IDLE;
            endcase
        end
    end
    // ------------------------------------------------------------
    // Frame hand-off through FIFO
    // ------------------------------------------------------------
    // Short frames are dropped so partial words never reach outputs
    wire push_v = (st_q == adsc_pkg::ADSC_SHIFT) && cs_rise && frame_full;
    wire push_rdy, pop_v;
    wire [FRAME_BITS-1:0] pop_data;
    adsc_fifo #(.WIDTH(FRAME_BITS), .DEPTH(DEPTH)) u_fifo (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .clr_i(standby),
        .in_valid_i(push_v),
        .in_ready_o(push_rdy),
        .in_data_i(rx_q),
        .out_valid_o(pop_v),
        .out_ready_i(1'b1),
        .out_data_o(pop_data)
    );
    // ------------------------------------------------------------
    // Input data register and outputs
    // ------------------------------------------------------------
    logic [FRAME_BITS-1:0] ctrl_q;
    logic test_q;
    // Latch a full frame; enable low restores defaults
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_q <= `ADSC_CTRL_RESET;
            test_q <= 1'b0;
        end else if (standby) begin
            ctrl_q <= `ADSC_CTRL_RESET; // RULE6
            test_q <= 1'b0;
        end else begin
            if (pop_v) ctrl_q <= pop_data; // RULE12
            test_q <= hv_q; // RULE9
        end
    end
    wire [2:0] sel = ctrl_q[`ADSC_SEL_MSB:`ADSC_SEL_LSB]; // RULE7
    // Host drives the pin when we release it; its level gates all loads
    wire pwm_gate = pwm_q; // RULE8
    wire [5:0] modes_d = (standby || !pwm_gate) ? 6'h00 : ctrl_q[5:0];
    wire [1:0] hs_d = (standby || !pwm_gate) ? 2'h0 : ctrl_q[7:6];
    wire [2:0] tsel = ctrl_q[`ADSC_TEST_SEL_LSB+2:`ADSC_TEST_SEL_LSB];
    wire mon_d = test_q ? diag_i[tsel] : 1'b0;
    // All outputs registered
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            serial_out_o <= 1'b0;
            serial_out_oe_o <= 1'b0;
            bridge_mode_o <= 6'h00;
            hs_on_o <= 2'h0;
            mon_sel_o <= 3'h0;
            monitor_pwm_pin_o <= 1'b0;
            monitor_pwm_pin_oe_o <= 1'b0;
            standby_o <= 1'b1;
            test_mode_o <= 1'b0;
        end else begin
            serial_out_o <= tx_q[0];
            serial_out_oe_o <= selected && !standby; // RULE3
            bridge_mode_o <= modes_d; // RULE10 RULE5
            hs_on_o <= hs_d; // RULE5
            mon_sel_o <= sel; // RULE7
            monitor_pwm_pin_o <= mon_d; // RULE9
            monitor_pwm_pin_oe_o <= test_q;
            standby_o <= standby; // RULE5
            test_mode_o <= test_q;
        end
    end
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence cs_high_s;
        cs_q && !selected;
    endsequence
    oe_deselect_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        cs_high_s |=> !serial_out_oe_o) // RULE3
        else $error("serial out driven while deselected");
    stby_off_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        standby |=> bridge_mode_o == 6'h00 && hs_on_o == 2'h0) // RULE5
        else $error("outputs on in standby");
    stby_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        standby |=> ctrl_q == `ADSC_CTRL_RESET && cnt_q == '0) // RULE6
        else $error("registers kept in standby");
    no_shift_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !sck_rise && !standby |=> $stable(rx_q)) // RULE4
        else $error("shift without serial clock");
    idle_ign_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !selected && !standby |=> $stable(cnt_q)) // RULE2
        else $error("traffic taken while deselected");
    sel_map_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        1'b1 |=> mon_sel_o == $past(ctrl_q[11:9])) // RULE7
        else $error("monitor select wrong");
    pwm_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !pwm_q |=> bridge_mode_o == 6'h00) // RULE8
        else $error("pwm low did not gate outputs");
    test_ent_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        hv_q && !standby ##1 !standby |=> test_mode_o) // RULE9
        else $error("test mode not entered");
    latch_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        push_v && push_rdy && !standby ##1 !standby ##1 !standby
        |=> ctrl_q == $past(rx_q, 3)) // RULE12
        else $error("frame not latched on deselect");
    // ------------------------------------------------------------
    // Assertions on the frame path, outputs and test mode
    // ------------------------------------------------------------
    // Deselect edge closing a frame that never reached full length
    sequence short_end_s;
        (st_q == adsc_pkg::ADSC_SHIFT) && cs_rise && !frame_full;
    endsequence
    // Select edge seen from idle while the port is awake
    sequence frame_start_s;
        (st_q == adsc_pkg::ADSC_IDLE) && cs_fall && !standby;
    endsequence
    // Two awake cycles, so a standby clear cannot mask a check
    sequence awake2_s;
        !standby ##1 !standby;
    endsequence
    // Output driver must come on while the host selects us
    oe_select_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        selected && !standby |=> serial_out_oe_o) // RULE3
        else $error("serial out idle while selected");
    // Long frames saturate; the count never runs past a frame
    cnt_range_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        cnt_q <= CW'(FRAME_BITS)) // RULE1
        else $error("bit count past frame length");
    // Diagnosis word captured at select, ready for the first bit
    tx_load_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        frame_start_s |=> tx_q == $past(diag_i)) // RULE11
        else $error("diagnosis word not loaded at select");
    // Receive register ignores the clock pin while deselected
    sel_only_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !selected && !standby |=> $stable(rx_q)) // RULE2
        else $error("data shifted while deselected");
    // Transmit word only moves at select or under a selected clock
    tx_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !selected && !standby && !cs_fall |=> $stable(tx_q)) // RULE11
        else $error("diagnosis word moved while deselected");
    // A cut frame must never reach the input data register
    short_drop_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        short_end_s ##0 awake2_s |=> $stable(ctrl_q)) // RULE12
        else $error("short frame reached the outputs");
    // Buffer drains every cycle, so a full frame is never refused
    fifo_room_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        push_v |-> push_rdy) // RULE12
        else $error("complete frame refused by hand-off buffer");
    // Low pin level also holds the high-side drivers off
    hs_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !pwm_q |=> hs_on_o == 2'h0) // RULE8
        else $error("pwm low did not gate high sides");
    // Pin left to the host outside test mode
    pin_release_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !test_q |=> !monitor_pwm_pin_oe_o) // RULE8
        else $error("monitor pin driven outside test mode");
    // Test mode drops two cycles after the high level goes
    test_exit_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !hv_q ##1 1'b1 |=> !test_mode_o) // RULE9
        else $error("test mode kept after high voltage gone");
    // Standby is reported on its flag one cycle later
    stby_flag_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        standby |=> standby_o) // RULE5
        else $error("standby not reported");
endmodule

// file: sim/adsc_host_model.sv
// Host serial master model for the control port.
// Assumes clk_i is the device clock; link edges land on it.
`timescale 1ns/1ps
module adsc_host_model (
    // Clock
    input wire logic clk_i,
    // Link
    input wire logic serial_out_i,
    output logic chip_select_n_o = 1'b1,
    output logic serial_clk_o = 1'b0,
    output logic serial_in_o = 1'b0
);
    // ------------------------------------------------------------
    // Frame transfer
    // ------------------------------------------------------------
    // Sends nbits, LSB first; half is half a link period in clk cycles.
    // Link clock stays low outside frames, so no stray edges.
    task automatic send(input logic [15:0] w, input int nbits,
                        input int half, output logic [15:0] rd);
        rd = 16'h0000;
        @(posedge clk_i);
        chip_select_n_o <= 1'b0;
        repeat (half) @(posedge clk_i);
        for (int i = 0; i < nbits; i++) begin
            serial_in_o <= w[i];
            repeat (half) @(posedge clk_i);
            serial_clk_o <= 1'b1;
            rd[i] = serial_out_i;
            repeat (half) @(posedge clk_i);
            serial_clk_o <= 1'b0;
        end
        repeat (half) @(posedge clk_i);
        chip_select_n_o <= 1'b1;
        serial_in_o <= ~serial_in_o; // Released line, no stale level
        repeat (16) @(posedge clk_i);
    endtask
endmodule

// file: sim/testbench.sv
// Self-checking bench for the actuator driver serial control port.
// Assumes the host model file is compiled first.
`timescale 1ns/1ps
module testbench;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic enable_i = 1'b0;
    logic test_hv_i = 1'b0;
    logic pwm_q = 1'b1;
    logic [15:0] diag_i = 16'ha5c3;
    wire logic cs_n, sck, sdi, sdo, sdo_oe, mon_o, mon_oe, mon_pin;
    wire logic sdo_pin;
    wire logic standby_o, test_mode_o;
    wire logic [5:0] bridge_mode_o;
    wire logic [1:0] hs_on_o;
    wire logic [2:0] mon_sel_o;
    int err_count = 0;
    int total_checks = 0;
    int cycles = 0;
    always #2.5 clk_i = ~clk_i;
    // Shared monitor pin: the device wins while it drives
    assign mon_pin = mon_oe ? mon_o : pwm_q;
    // Undriven serial out reads inverted, so a dead driver shows up
    assign sdo_pin = sdo_oe ? sdo : ~sdo;
    adsc_host_model adsc_host_model_i (.clk_i(clk_i), .serial_out_i(sdo_pin),
        .chip_select_n_o(cs_n), .serial_clk_o(sck), .serial_in_o(sdi));
    adsc_top #(.FRAME_BITS(16), .DEPTH(4)) adsc_top_i (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .chip_select_n_i(cs_n), .serial_clk_i(sck),
        .serial_in_i(sdi), .serial_out_o(sdo), .serial_out_oe_o(sdo_oe),
        .enable_i(enable_i), .test_hv_i(test_hv_i),
        .monitor_pwm_pin_i(mon_pin), .monitor_pwm_pin_o(mon_o),
        .monitor_pwm_pin_oe_o(mon_oe), .diag_i(diag_i),
        .bridge_mode_o(bridge_mode_o), .hs_on_o(hs_on_o),
        .mon_sel_o(mon_sel_o), .standby_o(standby_o),
        .test_mode_o(test_mode_o));
    // ------------------------------------------------------------
    // Checking and scenarios
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Every pair mode and selectors 3 to 6, prompt and slow link
    task automatic t_modes();
        logic [15:0] w, rd;
        for (int m = 0; m < 4; m++) begin
            w = {4'h0, 3'(m + 3), 1'b0, 2'(m), 2'(m + 2), 2'(m + 1), 2'(m)};
            adsc_host_model_i.send(w, 16, (m % 2) ? 24 : 16, rd);
            check("modes", 16'(w[5:0]), 16'(bridge_mode_o));
            check("hs", 16'(w[7:6]), 16'(hs_on_o));
            check("sel", 16'(w[11:9]), 16'(mon_sel_o));
            check("diag", diag_i, rd);
            check("oe", 16'h0000, 16'(sdo_oe));
        end
    endtask
    // Short frame, and a select with no clock, keep the last word;
    // 6'h13 is the pair field of the last word sent by t_modes
    task automatic t_short();
        logic [15:0] rd;
        adsc_host_model_i.send(16'hffff, 8, 16, rd);
        check("short", 16'h0013, 16'(bridge_mode_o));
        check("short diag", 16'(diag_i[7:0]), 16'(rd[7:0]));
        adsc_host_model_i.send(16'hffff, 0, 16, rd);
        check("still", 16'h0013, 16'(bridge_mode_o));
    endtask
    // Pin held low by the host gates the pair mode outputs
    task automatic t_pwm();
        pwm_q <= 1'b0;
        repeat (10) @(posedge clk_i);
        check("pwm low", 16'h0000, 16'(bridge_mode_o));
        pwm_q <= 1'b1;
        repeat (10) @(posedge clk_i);
        check("pwm high", 16'h0013, 16'(bridge_mode_o));
    endtask
    task automatic t_test();
        test_hv_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        check("test", 16'h0003, 16'({test_mode_o, mon_oe}));
        // Test select field is zero, so the pin shows diagnosis bit 0
        check("mon", 16'(diag_i[0]), 16'(mon_o));
        test_hv_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        check("untest", 16'h0000, 16'({test_mode_o, mon_oe}));
    endtask
    // Standby clears state; nothing returns after re-enable
    task automatic t_standby();
        enable_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        check("standby", 16'h0001, 16'(standby_o));
        check("off", 16'h0000, 16'({bridge_mode_o, hs_on_o, mon_sel_o}));
        enable_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        check("cleared", 16'h0000, 16'({bridge_mode_o, hs_on_o, mon_sel_o}));
    endtask
    // Frames back to back through the hand-off buffer, each latched
    task automatic t_burst();
        logic [15:0] w, rd;
        for (int k = 0; k < 4; k++) begin
            w = {4'h0, 3'(7 - k), 1'b0, 2'(k), 2'(k), 2'(3 - k), 2'(k)};
            adsc_host_model_i.send(w, 16, 16, rd);
            check("burst modes", 16'(w[5:0]), 16'(bridge_mode_o));
            check("burst hs", 16'(w[7:6]), 16'(hs_on_o));
            check("burst sel", 16'(w[11:9]), 16'(mon_sel_o));
        end
    endtask
    // Hang guard, well above the whole sequence
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            err_count++;
            finish_test();
        end
    end
    initial begin
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        enable_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        t_modes();
        t_short();
        t_pwm();
        t_test();
        t_standby();
        t_burst();
        finish_test();
    end
endmodule
